//--- pcie_capability_id_registers.sv
// The strobed register port was chosen for this implementation.
module pcie_capability_id_registers #(
    parameter bit IS_UPSTREAM = 1'b1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [capid_pkg::ADDR_W-1:0] regAddr,
    input wire logic [capid_pkg::DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [capid_pkg::DATA_W-1:0] regRdData,
    // Strap pin and hardware initialisation loads
    input wire logic slotStrap,
    input wire capid_pkg::initLoad_s initLoad,
    // Received slot power limit message
    input wire capid_pkg::slotPwrMsg_s slotPwrMsg,
    // Strap capture finished
    output logic strapDone
);

    // ------------------------------------------------------------
    // Decoding and word assembly
    // ------------------------------------------------------------
    function automatic logic hitsAddr(input logic [capid_pkg::ADDR_W-1:0] addr,
                                      input logic [capid_pkg::ADDR_W-1:0] ofs);
        hitsAddr = (addr == ofs);
    endfunction

    localparam logic [3:0] PORT_TYPE_RST = IS_UPSTREAM ? capid_pkg::PORT_TYPE_UP
                                                       : capid_pkg::PORT_TYPE_DOWN;

    typedef enum logic [1:0] {
        ST_SETTLE0 = 2'b00,
        ST_SETTLE1 = 2'b01,
        ST_CAPTURE = 2'b11,
        ST_DONE = 2'b10
    } strap_e;

    strap_e strapState_q;
    strap_e strapState_d;
    logic slotImpl_q;
    logic slotImpl_d;
    logic [2:0] mps_q;
    logic [2:0] mps_d;
    logic rber_q;
    logic rber_d;
    logic [7:0] splVal_q;
    logic [7:0] splVal_d;
    logic [1:0] splScale_q;
    logic [1:0] splScale_d;
    logic [capid_pkg::DATA_W-1:0] rdData_q;
    logic [capid_pkg::DATA_W-1:0] rdData_d;
    logic [capid_pkg::DATA_W-1:0] capWord;
    logic [capid_pkg::DATA_W-1:0] devWord;
    logic strapSync;
    logic unusedWr;

    // ------------------------------------------------------------
    // Strap pin synchroniser
    // ------------------------------------------------------------
    level_sync #(
        .WIDTH(1)
    ) u_strap_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .asyncIn(slotStrap),
        .syncOut(strapSync)
    );

    // ------------------------------------------------------------
    // Strap capture sequence
    // ------------------------------------------------------------
    // The synchroniser is cleared by reset, so the strap is taken only
    // once both stages hold the pin level again.
    always_comb begin
        case (strapState_q)
            ST_SETTLE0: strapState_d = ST_SETTLE1;
            ST_SETTLE1: strapState_d = ST_CAPTURE;
            ST_CAPTURE: strapState_d = ST_DONE;
            ST_DONE: strapState_d = ST_DONE;
            default: strapState_d = ST_SETTLE0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            strapState_q <= ST_SETTLE0;
        end else begin
            strapState_q <= strapState_d;
        end
    end

    assign strapDone = (strapState_q == ST_DONE);

    // ------------------------------------------------------------
    // Loadable fields
    // ------------------------------------------------------------
    // A load from the init port wins over the strap in the same cycle,
    // since SMBus and EEPROM values are meant to override the pin.
    always_comb begin
        slotImpl_d = slotImpl_q;
        mps_d = mps_q;
        rber_d = rber_q;
        if (strapState_q == ST_CAPTURE) begin
            slotImpl_d = strapSync;
        end
        if (initLoad.valid) begin
            case (initLoad.field)
                capid_pkg::FLD_SLOT_IMPL: slotImpl_d = initLoad.data[0];
                capid_pkg::FLD_MPS: mps_d = initLoad.data[2:0];
                capid_pkg::FLD_RBER: rber_d = initLoad.data[0];
                default: slotImpl_d = slotImpl_q;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            slotImpl_q <= capid_pkg::SLOT_IMPL_RST;
            mps_q <= capid_pkg::MPS_RST;
            rber_q <= capid_pkg::RBER_RST;
        end else begin
            slotImpl_q <= slotImpl_d;
            mps_q <= mps_d;
            rber_q <= rber_d;
        end
    end

    // ------------------------------------------------------------
    // Captured slot power limit
    // ------------------------------------------------------------
    // Value and scale always move together so software never sees a
    // value paired with the scale of an older message.
    always_comb begin
        splVal_d = splVal_q;
        splScale_d = splScale_q;
        if (IS_UPSTREAM && slotPwrMsg.valid) begin
            splVal_d = slotPwrMsg.value;
            splScale_d = slotPwrMsg.scale;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            splVal_q <= capid_pkg::SPL_VAL_RST;
            splScale_q <= capid_pkg::SPL_SCALE_RST;
        end else begin
            splVal_q <= splVal_d;
            splScale_q <= splScale_d;
        end
    end

    // ------------------------------------------------------------
    // Read words
    // ------------------------------------------------------------
    always_comb begin
        capWord = '0;
        capWord[capid_pkg::CAP_VER_LSB +: capid_pkg::CAP_VER_W] = capid_pkg::CAP_VER_VAL;
        capWord[capid_pkg::PORT_TYPE_LSB +: capid_pkg::PORT_TYPE_W] = PORT_TYPE_RST;
        capWord[capid_pkg::SLOT_IMPL_BIT] = IS_UPSTREAM ? 1'b0 : slotImpl_q;
        capWord[capid_pkg::INT_MSG_LSB +: capid_pkg::INT_MSG_W] = capid_pkg::INT_MSG_VAL;
    end

    always_comb begin
        devWord = '0;
        devWord[capid_pkg::MPS_LSB +: capid_pkg::MPS_W] = mps_q;
        devWord[capid_pkg::PHANTOM_LSB +: capid_pkg::PHANTOM_W] = capid_pkg::PHANTOM_VAL;
        devWord[capid_pkg::EXT_TAG_BIT] = capid_pkg::EXT_TAG_VAL;
        devWord[capid_pkg::L0S_LSB +: capid_pkg::L0S_W] = capid_pkg::L0S_VAL;
        devWord[capid_pkg::L1_LSB +: capid_pkg::L1_W] = capid_pkg::L1_VAL;
        devWord[capid_pkg::RBER_BIT] = rber_q;
        devWord[capid_pkg::SPL_VAL_LSB +: capid_pkg::SPL_VAL_W] = splVal_q;
        devWord[capid_pkg::SPL_SCALE_LSB +: capid_pkg::SPL_SCALE_W] = splScale_q;
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    // Every field is read-only, so a write strobe is accepted and dropped.
    assign unusedWr = regWr & (|regWrData);

    always_comb begin
        rdData_d = '0;
        if (regRd && hitsAddr(regAddr, capid_pkg::OFS_CAP_UPPER)) begin
            rdData_d = capWord;
        end else if (regRd && hitsAddr(regAddr, capid_pkg::OFS_DEV_CAP)) begin
            rdData_d = devWord;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdData_q <= '0;
        end else begin
            rdData_q <= rdData_d;
        end
    end

    assign regRdData = rdData_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_cap_version: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (regRd && hitsAddr(regAddr, capid_pkg::OFS_CAP_UPPER)) |=>
        (regRdData[19:16] == 4'h1))
        else $error("capability version wrong");

    chk_port_type: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (regRd && hitsAddr(regAddr, capid_pkg::OFS_CAP_UPPER)) |=>
        (regRdData[23:20] == (IS_UPSTREAM ? 4'h5 : 4'h6)))
        else $error("port type wrong");

    chk_slot_read: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (regRd && hitsAddr(regAddr, capid_pkg::OFS_CAP_UPPER)) |=>
        (regRdData[24] == (IS_UPSTREAM ? 1'b0 : $past(slotImpl_q))))
        else $error("slot implemented bit wrong");

    chk_slot_strap: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (strapState_q == ST_CAPTURE && !initLoad.valid) |=>
        (slotImpl_q == $past(strapSync)) ##1 (strapState_q == ST_DONE))
        else $error("strap not captured");

    chk_slot_nowrite: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (regWr && !initLoad.valid && strapState_q == ST_DONE) |=> $stable(slotImpl_q))
        else $error("software write changed slot bit");

    chk_int_msg: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (regRd && hitsAddr(regAddr, capid_pkg::OFS_CAP_UPPER)) |=>
        (regRdData[29:25] == 5'h00))
        else $error("interrupt message number not zero");

    chk_mps_reset: assert property (
        @(posedge ref_clk)
        (sys_rst ##1 !sys_rst) |-> (mps_q == 3'h1))
        else $error("max payload reset value wrong");

    chk_phantom_zero: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (regRd && hitsAddr(regAddr, capid_pkg::OFS_DEV_CAP)) |=> (regRdData[4:3] == 2'h0))
        else $error("phantom field not zero");

    chk_ext_tag: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (regRd && hitsAddr(regAddr, capid_pkg::OFS_DEV_CAP)) |=> !regRdData[5])
        else $error("extended tag bit set");

    chk_l0s_latency: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (regRd && hitsAddr(regAddr, capid_pkg::OFS_DEV_CAP)) |=> (regRdData[8:6] == 3'h0))
        else $error("L0s latency not zero");

    chk_l1_latency: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (regRd && hitsAddr(regAddr, capid_pkg::OFS_DEV_CAP)) |=> (regRdData[11:9] == 3'h0))
        else $error("L1 latency not zero");

    chk_rber_reset: assert property (
        @(posedge ref_clk)
        (sys_rst ##1 !sys_rst) |-> rber_q)
        else $error("role-based error bit reset wrong");

    chk_spl_value: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (slotPwrMsg.valid && IS_UPSTREAM) ##1 (regRd && hitsAddr(regAddr, capid_pkg::OFS_DEV_CAP)
        && !slotPwrMsg.valid) |=> (regRdData[25:18] == $past(slotPwrMsg.value, 2)))
        else $error("slot power value not captured");

    chk_spl_scale: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        slotPwrMsg.valid |=> (splScale_q == (IS_UPSTREAM ? $past(slotPwrMsg.scale) : 2'h0)))
        else $error("slot power scale not captured");

    chk_reserved_zero: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (regRd && hitsAddr(regAddr, capid_pkg::OFS_DEV_CAP)) |=>
        (regRdData[14:12] == 3'h0 && regRdData[17:16] == 2'h0 && regRdData[31:28] == 4'h0))
        else $error("reserved bits not zero");

    chk_idle_zero: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (!regRd || !(hitsAddr(regAddr, capid_pkg::OFS_CAP_UPPER)
        || hitsAddr(regAddr, capid_pkg::OFS_DEV_CAP))) |=> (regRdData == 32'h0000_0000))
        else $error("read data outside answer cycle");

endmodule // pcie_capability_id_registers

//--- capid_pkg.sv
package capid_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFS_CAP_UPPER = 8'he0;
    localparam logic [7:0] OFS_DEV_CAP = 8'he4;

    // ------------------------------------------------------------
    // Capabilities word at OFS_CAP_UPPER (upper half)
    // ------------------------------------------------------------
    localparam int CAP_VER_LSB = 16;
    localparam int CAP_VER_W = 4;
    localparam int PORT_TYPE_LSB = 20;
    localparam int PORT_TYPE_W = 4;
    localparam int SLOT_IMPL_BIT = 24;
    localparam int INT_MSG_LSB = 25;
    localparam int INT_MSG_W = 5;
    localparam int CAP_RSVD_LSB = 30;
    localparam int CAP_RSVD_W = 2;
    localparam logic [3:0] CAP_VER_VAL = 4'h1;
    localparam logic [3:0] PORT_TYPE_UP = 4'h5;
    localparam logic [3:0] PORT_TYPE_DOWN = 4'h6;
    localparam logic [4:0] INT_MSG_VAL = 5'h00;
    localparam logic SLOT_IMPL_RST = 1'b0;

    // ------------------------------------------------------------
    // Device capabilities word at OFS_DEV_CAP
    // ------------------------------------------------------------
    localparam int MPS_LSB = 0;
    localparam int MPS_W = 3;
    localparam int PHANTOM_LSB = 3;
    localparam int PHANTOM_W = 2;
    localparam int EXT_TAG_BIT = 5;
    localparam int L0S_LSB = 6;
    localparam int L0S_W = 3;
    localparam int L1_LSB = 9;
    localparam int L1_W = 3;
    localparam int RSVD_A_LSB = 12;
    localparam int RSVD_A_W = 3;
    localparam int RBER_BIT = 15;
    localparam int RSVD_B_LSB = 16;
    localparam int RSVD_B_W = 2;
    localparam int SPL_VAL_LSB = 18;
    localparam int SPL_VAL_W = 8;
    localparam int SPL_SCALE_LSB = 26;
    localparam int SPL_SCALE_W = 2;
    localparam int RSVD_C_LSB = 28;
    localparam int RSVD_C_W = 4;
    localparam logic [2:0] MPS_RST = 3'h1;
    localparam logic [1:0] PHANTOM_VAL = 2'h0;
    localparam logic EXT_TAG_VAL = 1'b0;
    localparam logic [2:0] L0S_VAL = 3'h0;
    localparam logic [2:0] L1_VAL = 3'h0;
    localparam logic RBER_RST = 1'b1;
    localparam logic [7:0] SPL_VAL_RST = 8'h00;
    localparam logic [1:0] SPL_SCALE_RST = 2'h0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FLD_SLOT_IMPL = 2'h0,
        FLD_MPS = 2'h1,
        FLD_RBER = 2'h2
    } initField_e;

    typedef struct packed {
        logic valid;
        initField_e field;
        logic [7:0] data;
    } initLoad_s;

    typedef struct packed {
        logic valid;
        logic [7:0] value;
        logic [1:0] scale;
    } slotPwrMsg_s;

endpackage

//--- level_sync.sv
module level_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Levels
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage1_d;
    logic [WIDTH-1:0] stage2_q;
    logic [WIDTH-1:0] stage2_d;

    always_comb begin
        stage1_d = asyncIn;
        stage2_d = stage1_q;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            stage1_q <= '0;
            stage2_q <= '0;
        end else begin
            stage1_q <= stage1_d;
            stage2_q <= stage2_d;
        end
    end

    assign syncOut = stage2_q;

endmodule // level_sync

//--- pcie_capability_id_registers_tb_top.sv
module pcie_capability_id_registers_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic slotStrap = 1'b0;
    capid_pkg::initLoad_s initLoad = '0;
    capid_pkg::slotPwrMsg_s slotPwrMsg = '0;
    logic [31:0] rdUp;
    logic [31:0] rdDn;
    logic doneUp;
    logic doneDn;
    int n_errors = 0;
    int comparisons = 0;

    // Expected field contents, kept from the stimulus alone
    logic expSlot;
    logic [2:0] expMps;
    logic expRber;
    logic [7:0] expSplVal;
    logic [1:0] expSplScale;

    always #25 ref_clk = ~ref_clk;

    // ------------------------------------------------------------
    // Both port flavours see the same stimulus
    // ------------------------------------------------------------
    pcie_capability_id_registers #(.IS_UPSTREAM(1'b1)) DUT (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(rdUp), .slotStrap(slotStrap),
        .initLoad(initLoad), .slotPwrMsg(slotPwrMsg), .strapDone(doneUp)
    );
    pcie_capability_id_registers #(.IS_UPSTREAM(1'b0)) dutDown (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(rdDn), .slotStrap(slotStrap),
        .initLoad(initLoad), .slotPwrMsg(slotPwrMsg), .strapDone(doneDn)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Slot bit only carries meaning downstream, upstream reads it as zero
    function automatic logic [31:0] capWord(input bit up);
        return {2'h0, 5'h00, (up ? 1'b0 : expSlot), (up ? 4'h5 : 4'h6), 4'h1, 16'h0000};
    endfunction

    function automatic logic [31:0] devWord(input bit up);
        return {4'h0, (up ? expSplScale : 2'h0), (up ? expSplVal : 8'h00), 2'h0, expRber,
                3'h0, 3'h0, 3'h0, 1'b0, 2'h0, expMps};
    endfunction

    task automatic rdWord(input logic [7:0] a, output logic [31:0] up, output logic [31:0] dn);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        @(negedge ref_clk);
        up = rdUp;
        dn = rdDn;
    endtask

    task automatic wrWord(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask

    task automatic load(input logic [1:0] f, input logic [7:0] d);
        @(posedge ref_clk);
        initLoad <= '{1'b1, capid_pkg::initField_e'(f), d};
        @(posedge ref_clk);
        initLoad.valid <= 1'b0;
    endtask

    task automatic checkAll();
        logic [31:0] up;
        logic [31:0] dn;
        rdWord(capid_pkg::OFS_CAP_UPPER, up, dn);
        check("cap word up", up, capWord(1'b1));
        check("cap word down", dn, capWord(1'b0));
        rdWord(capid_pkg::OFS_DEV_CAP, up, dn);
        check("dev word up", up, devWord(1'b1));
        check("dev word down", dn, devWord(1'b0));
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Reset mid-run too: every loaded or captured field must fall back
    task automatic test_reset_values(input logic strap);
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        slotStrap <= strap;
        repeat (6) @(posedge ref_clk);
        check("done in reset", {30'h0, doneUp, doneDn}, 32'h0);
        sys_rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        check("strap done", {30'h0, doneUp, doneDn}, 32'h3);
        expSlot = strap;
        expMps = 3'h1;
        expRber = 1'b1;
        expSplVal = 8'h00;
        expSplScale = 2'h0;
        checkAll();
    endtask

    // All ones written everywhere, then back-to-back reads and an unmapped read
    task automatic test_writes_ignored();
        logic [31:0] up;
        logic [31:0] dn;
        wrWord(capid_pkg::OFS_CAP_UPPER, 32'hffffffff);
        wrWord(capid_pkg::OFS_DEV_CAP, 32'hffffffff);
        wrWord(8'he8, 32'hffffffff);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= capid_pkg::OFS_CAP_UPPER;
        @(posedge ref_clk);
        regAddr <= capid_pkg::OFS_DEV_CAP;
        @(negedge ref_clk);
        check("cap after write", rdUp, capWord(1'b1));
        @(posedge ref_clk);
        regRd <= 1'b0;
        @(negedge ref_clk);
        check("dev after write", rdUp, devWord(1'b1));
        @(negedge ref_clk);
        check("idle read data", rdUp | rdDn, 32'h0);
        rdWord(8'he8, up, dn);
        check("unmapped read", up | dn, 32'h0);
        checkAll();
    endtask

    task automatic test_init_loads();
        load(2'h1, 8'hff);
        load(2'h2, 8'hfe);
        load(2'h0, 8'hfe);
        load(2'h3, 8'hff);
        expMps = 3'h7;
        expRber = 1'b0;
        expSlot = 1'b0;
        checkAll();
        load(2'h1, 8'h02);
        load(2'h2, 8'h01);
        load(2'h0, 8'h01);
        expMps = 3'h2;
        expRber = 1'b1;
        expSlot = 1'b1;
        checkAll();
    endtask

    // Two messages back to back: the second one must win as a whole
    task automatic test_slot_power();
        @(posedge ref_clk);
        slotPwrMsg <= '{1'b1, 8'h5a, 2'h2};
        @(posedge ref_clk);
        slotPwrMsg <= '{1'b1, 8'ha5, 2'h1};
        @(posedge ref_clk);
        slotPwrMsg.valid <= 1'b0;
        regRd <= 1'b1;
        regAddr <= capid_pkg::OFS_DEV_CAP;
        expSplVal = 8'ha5;
        expSplScale = 2'h1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        @(negedge ref_clk);
        check("dev word right after message", rdUp, devWord(1'b1));
        checkAll();
        @(posedge ref_clk);
        slotPwrMsg <= '{1'b1, 8'hff, 2'h3};
        @(posedge ref_clk);
        slotPwrMsg.valid <= 1'b0;
        expSplVal = 8'hff;
        expSplScale = 2'h3;
        checkAll();
    endtask

    // The strap is only looked at once after reset
    task automatic test_strap_late();
        @(posedge ref_clk);
        slotStrap <= ~expSlot;
        repeat (6) @(posedge ref_clk);
        checkAll();
    endtask

    // ------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ------------------------------------------------------------
    task automatic print_verdict();
        if (n_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // The whole sequence needs about a hundred cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_errors++;
        print_verdict();
    end

    initial begin
        test_reset_values(1'b1);
        test_writes_ignored();
        test_init_loads();
        test_slot_power();
        test_strap_late();
        test_reset_values(1'b0);
        print_verdict();
    end
endmodule // pcie_capability_id_registers_tb_top
